// *** cpx_alu.sv ***
// address alu: add, subtract, compare and rotate on 20-bit values with flags
module cpx_alu
  (
    // operation
    input wire cpx_pkg::cpx_op_t op_in,
    input wire cpx_pkg::cpx_rot_t rot_in,
    input wire logic carry_in,
    // operands
    input wire logic [19:0] a_in,
    input wire logic [19:0] b_in,
    // results
    output logic [19:0] result_out,
    output logic write_out,
    output logic [3:0] flags_out
  );

  logic [20:0] sum;
  logic [20:0] diff;

  always_comb
  begin
    sum = {1'b0, a_in} + {1'b0, b_in};
    diff = {1'b0, a_in} + {1'b0, ~b_in} + 21'h000001;
    result_out = a_in;
    write_out = 1'b0;
    flags_out = 4'h0;
    unique case (op_in)
      cpx_pkg::OP_ADDR_ADD, cpx_pkg::OP_EXT_ADD:
      begin
        result_out = sum[19:0];
        write_out = 1'b1;
        flags_out = {(a_in[19] == b_in[19]) && (sum[19] != a_in[19]), sum[19], sum[19:0] == 20'h00000, sum[20]};
      end
      cpx_pkg::OP_ADDR_SUB, cpx_pkg::OP_EXT_SUB, cpx_pkg::OP_ADDR_COMPARE, cpx_pkg::OP_EXT_COMPARE:
      begin
        result_out = diff[19:0];
        write_out = (op_in == cpx_pkg::OP_ADDR_SUB) || (op_in == cpx_pkg::OP_EXT_SUB);
        flags_out = {(a_in[19] != b_in[19]) && (diff[19] != a_in[19]), diff[19], diff[19:0] == 20'h00000,
                     diff[20]};
      end
      cpx_pkg::OP_ROTATE:
      begin
        write_out = 1'b1;
        unique case (rot_in)
          cpx_pkg::ROT_RRC: result_out = {carry_in, a_in[19:1]};
          cpx_pkg::ROT_RRA: result_out = {a_in[19], a_in[19:1]};
          cpx_pkg::ROT_RLA: result_out = {a_in[18:0], 1'b0};
          cpx_pkg::ROT_RRU: result_out = {1'b0, a_in[19:1]};
        endcase
        flags_out = {1'b0, result_out[19], result_out == 20'h00000,
                     (rot_in == cpx_pkg::ROT_RLA) ? a_in[19] : a_in[0]};
      end
      cpx_pkg::OP_BIT_TEST:
      begin
        result_out = a_in & b_in;
        flags_out = {1'b0, result_out[19], result_out == 20'h00000, result_out != 20'h00000};
      end
      default:
      begin
        result_out = a_in;
      end
    endcase
  end

endmodule

// *** cpx_exec.sv ***
// execute stage with corrected program counter and stack pointer corner cases
// Behaviour
// - address arithmetic immediate on pc counts four bytes
// - immediate move to pc keeps normal accounting
// - extended add/sub/compare use correct pc
// - push 20-bit of sp auto-increment lowers sp four
// - call with pc target saves correct return
// - indexed sp call sign-extends index to 20 bits
// - indexed sp call independent of preceding push mode
// - untaken jump then pc rotate keeps running
// - indirect bit test on pc counts two bytes
// - loop exit traces the fall-through instruction
// - execution follows true flow, trace aside
module cpx_exec
  (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // decoded instruction from fetch
    input wire logic instr_valid_in,
    input wire cpx_pkg::cpx_instr_t instr_in,
    output logic instr_ready_out,
    // stack memory
    output cpx_pkg::cpx_stack_req_t stack_req_out,
    input wire logic [19:0] stack_rdata_in,
    input wire logic stack_ack_in,
    // program flow
    output logic [19:0] pc_out,
    output logic [19:0] sp_out,
    output logic [15:0] status_flags_reg_out,
    output logic halted_out,
    // debug trace
    output logic trace_valid_out,
    output cpx_pkg::cpx_trace_t trace_out
  );

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_STACK = 2'b01,
    ST_READ = 2'b10
  } cpx_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  cpx_state_t state_q;
  cpx_state_t state_d;
  logic [19:0] pc_q;
  logic [19:0] pc_d;
  logic [19:0] sp_q;
  logic [19:0] sp_d;
  logic [15:0] flags_q;
  logic [15:0] flags_d;
  cpx_pkg::cpx_stack_req_t req_q;
  cpx_pkg::cpx_stack_req_t req_d;
  logic [19:0] target_q;
  logic [19:0] target_d;
  logic trace_valid_q;
  cpx_pkg::cpx_trace_t trace_q;

  ////////////////////////////////////////////////////////////////////////////////
  // operand preparation

  logic [19:0] len;
  logic [19:0] pc_operand;
  logic [19:0] next_pc;
  logic [19:0] alu_a;
  logic [19:0] alu_b;
  logic [19:0] alu_res;
  logic alu_wr;
  logic [3:0] alu_flags;
  logic jump_taken;
  logic [19:0] idx_ext;
  logic take;

  assign take = instr_valid_in && (state_q == ST_EXEC);

  always_comb
  begin
    unique case (instr_in.op)
      cpx_pkg::OP_ADDR_ADD, cpx_pkg::OP_ADDR_SUB, cpx_pkg::OP_ADDR_COMPARE: len = cpx_pkg::LEN_ADDR_IMM;
      cpx_pkg::OP_EXT_ADD, cpx_pkg::OP_EXT_SUB, cpx_pkg::OP_EXT_COMPARE: len = cpx_pkg::LEN_EXT_IMM;
      cpx_pkg::OP_MOV_IMM: len = cpx_pkg::LEN_MOV_IMM;
      cpx_pkg::OP_PUSH_20BIT: len = cpx_pkg::LEN_PUSH;
      cpx_pkg::OP_CALL_20BIT: len = cpx_pkg::LEN_CALL_REG;
      cpx_pkg::OP_CALL_20BIT_IDX: len = cpx_pkg::LEN_CALL_IDX;
      cpx_pkg::OP_COND_JUMP: len = cpx_pkg::LEN_JUMP;
      cpx_pkg::OP_ROTATE: len = cpx_pkg::LEN_ROT;
      cpx_pkg::OP_BIT_TEST: len = cpx_pkg::LEN_BIT_IND;
      default: len = cpx_pkg::LEN_ROT;
    endcase
  end

  // pc as operand always reflects the whole encoding, never a partial count
  assign pc_operand = pc_q + len;
  assign next_pc = pc_q + len;

  // index sign-extended from 16 bits; no dependency on earlier push state
  assign idx_ext = {{4{instr_in.imm[15]}}, instr_in.imm[15:0]};

  always_comb
  begin
    unique case (instr_in.cond)
      cpx_pkg::JC_ZERO: jump_taken = flags_q[cpx_pkg::FLAG_Z];
      cpx_pkg::JC_NONZERO: jump_taken = !flags_q[cpx_pkg::FLAG_Z];
      cpx_pkg::JC_CARRY: jump_taken = flags_q[cpx_pkg::FLAG_C];
      cpx_pkg::JC_NO_CARRY: jump_taken = !flags_q[cpx_pkg::FLAG_C];
      cpx_pkg::JC_NEGATIVE: jump_taken = flags_q[cpx_pkg::FLAG_N];
      cpx_pkg::JC_GREATER_EQUAL: jump_taken = flags_q[cpx_pkg::FLAG_N] == flags_q[cpx_pkg::FLAG_V];
      cpx_pkg::JC_LESS: jump_taken = flags_q[cpx_pkg::FLAG_N] != flags_q[cpx_pkg::FLAG_V];
      default: jump_taken = 1'b0;
    endcase
  end

  always_comb
  begin
    alu_a = (instr_in.dst == cpx_pkg::REG_PC) ? pc_operand : instr_in.src_val;
    alu_b = instr_in.imm;
    if (instr_in.op == cpx_pkg::OP_BIT_TEST)
    begin
      alu_b = instr_in.src_val;
    end
  end

  cpx_alu u_alu
  (
    .op_in(instr_in.op),
    .rot_in(instr_in.rot),
    .carry_in(flags_q[cpx_pkg::FLAG_C]),
    .a_in(alu_a),
    .b_in(alu_b),
    .result_out(alu_res),
    .write_out(alu_wr),
    .flags_out(alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next-state decode

  always_comb
  begin
    state_d = state_q;
    pc_d = pc_q;
    sp_d = sp_q;
    flags_d = flags_q;
    req_d = req_q;
    target_d = target_q;
    unique case (state_q)
      ST_EXEC:
      begin
        if (instr_valid_in)
        begin
          pc_d = next_pc;
          unique case (instr_in.op)
            cpx_pkg::OP_ADDR_ADD, cpx_pkg::OP_ADDR_SUB, cpx_pkg::OP_ADDR_COMPARE,
            cpx_pkg::OP_EXT_ADD, cpx_pkg::OP_EXT_SUB, cpx_pkg::OP_EXT_COMPARE:
            begin
              flags_d[cpx_pkg::FLAG_C] = alu_flags[0];
              flags_d[cpx_pkg::FLAG_Z] = alu_flags[1];
              flags_d[cpx_pkg::FLAG_N] = alu_flags[2];
              flags_d[cpx_pkg::FLAG_V] = alu_flags[3];
              if (alu_wr && (instr_in.dst == cpx_pkg::REG_PC))
              begin
                pc_d = alu_res;
              end
              else if (alu_wr && (instr_in.dst == cpx_pkg::REG_SP))
              begin
                sp_d = alu_res;
              end
            end
            cpx_pkg::OP_MOV_IMM:
            begin
              if (instr_in.dst == cpx_pkg::REG_PC)
              begin
                pc_d = instr_in.imm;
              end
              else if (instr_in.dst == cpx_pkg::REG_SP)
              begin
                sp_d = instr_in.imm;
              end
            end
            cpx_pkg::OP_PUSH_20BIT:
            begin
              // sp source with auto-increment: pushed word is the old top, sp only drops by four
              sp_d = sp_q - cpx_pkg::PUSH_20BIT_BYTES;
              req_d = '{rd: 1'b0, wr: 1'b1, addr: sp_q - cpx_pkg::PUSH_20BIT_BYTES, wdata: instr_in.src_val};
              // resume after the push itself, whatever word was pushed
              target_d = next_pc;
              state_d = ST_STACK;
            end
            cpx_pkg::OP_CALL_20BIT:
            begin
              // return address is the instruction after the call, pc target or not
              sp_d = sp_q - cpx_pkg::PUSH_20BIT_BYTES;
              req_d = '{rd: 1'b0, wr: 1'b1, addr: sp_q - cpx_pkg::PUSH_20BIT_BYTES, wdata: next_pc};
              target_d = (instr_in.src == cpx_pkg::REG_PC) ? pc_operand : instr_in.src_val;
              state_d = ST_STACK;
            end
            cpx_pkg::OP_CALL_20BIT_IDX:
            begin
              // target is read from memory at sp plus the signed index, before sp moves
              sp_d = sp_q - cpx_pkg::PUSH_20BIT_BYTES;
              req_d = '{rd: 1'b1, wr: 1'b0, addr: sp_q + idx_ext, wdata: next_pc};
              state_d = ST_READ;
            end
            cpx_pkg::OP_COND_JUMP:
            begin
              // untaken: plain fall-through, the following word is not skipped
              pc_d = jump_taken ? (next_pc + {instr_in.imm[18:0], 1'b0}) : next_pc;
            end
            cpx_pkg::OP_ROTATE:
            begin
              flags_d[cpx_pkg::FLAG_C] = alu_flags[0];
              flags_d[cpx_pkg::FLAG_Z] = alu_flags[1];
              flags_d[cpx_pkg::FLAG_N] = alu_flags[2];
              if (instr_in.dst == cpx_pkg::REG_PC)
              begin
                pc_d = alu_res;
              end
            end
            cpx_pkg::OP_BIT_TEST:
            begin
              flags_d[cpx_pkg::FLAG_C] = alu_flags[0];
              flags_d[cpx_pkg::FLAG_Z] = alu_flags[1];
              flags_d[cpx_pkg::FLAG_N] = alu_flags[2];
              flags_d[cpx_pkg::FLAG_V] = 1'b0;
            end
            default:
            begin
              pc_d = next_pc;
            end
          endcase
        end
      end
      ST_READ:
      begin
        if (stack_ack_in)
        begin
          target_d = stack_rdata_in;
          req_d = '{rd: 1'b0, wr: 1'b1, addr: sp_q, wdata: req_q.wdata};
          state_d = ST_STACK;
        end
      end
      ST_STACK:
      begin
        if (stack_ack_in)
        begin
          req_d = '{rd: 1'b0, wr: 1'b0, addr: 20'h00000, wdata: 20'h00000};
          state_d = ST_EXEC;
          // a pushed word equal to pc must not redirect flow
          pc_d = target_q;
        end
      end
      default:
      begin
        state_d = ST_EXEC;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= ST_EXEC;
      pc_q <= cpx_pkg::PC_RESET;
      sp_q <= cpx_pkg::SP_RESET;
      flags_q <= cpx_pkg::FLAGS_RESET;
      req_q <= '0;
      target_q <= 20'h00000;
    end
    else
    begin
      state_q <= state_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      flags_q <= flags_d;
      req_q <= req_d;
      target_q <= target_d;
    end
  end

  // trace records the pc actually executed, so a loop exit shows the fall-through
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      trace_valid_q <= 1'b0;
      trace_q <= '0;
    end
    else
    begin
      trace_valid_q <= take;
      if (take)
      begin
        trace_q <= '{pc: pc_q, op: instr_in.op};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign instr_ready_out = (state_q == ST_EXEC);
  assign stack_req_out = req_q;
  assign pc_out = pc_q;
  assign sp_out = sp_q;
  assign status_flags_reg_out = flags_q;
  // the corrected core has no stall-forever path
  assign halted_out = 1'b0;
  assign trace_valid_out = trace_valid_q;
  assign trace_out = trace_q;

endmodule

// *** cpx_exec_checker.sv ***
// checker: port-level properties of the pc/sp corner-case execute stage
module cpx_exec_checker
  (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // instruction port
    input wire logic instr_valid_in,
    input wire cpx_pkg::cpx_instr_t instr_in,
    input wire logic instr_ready_out,
    // stack port
    input wire cpx_pkg::cpx_stack_req_t stack_req_out,
    input wire logic stack_ack_in,
    // flow and trace
    input wire logic [19:0] pc_out,
    input wire logic [19:0] sp_out,
    input wire logic halted_out,
    input wire logic trace_valid_out,
    input wire cpx_pkg::cpx_trace_t trace_out
  );
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic take;
  logic pc_imm;
  logic busy;
  assign take = instr_valid_in && instr_ready_out;
  assign pc_imm = take && instr_in.mode == cpx_pkg::MODE_IMM && instr_in.dst == cpx_pkg::REG_PC;
  assign busy = stack_req_out.rd || stack_req_out.wr;
  ////////////////////////////////////////////////////////////////////////////////
  a_never_halts: assert property (halted_out == 1'b0)
    else $error("core halted");
  a_rotate_pc_runs: assert property (take && instr_in.op == cpx_pkg::OP_ROTATE
    && instr_in.dst == cpx_pkg::REG_PC && instr_in.rot == cpx_pkg::ROT_RLA
    |=> !halted_out && pc_out == {$past(pc_out[18:0]) + 19'h00002, 1'b0})
    else $error("rotate on pc stalled or wrong");
  a_trace_on_take: assert property (take |=> trace_valid_out && trace_out.pc == $past(pc_out)
    && trace_out.op == $past(instr_in.op)) else $error("trace record wrong");
  a_addr_add_pc: assert property (pc_imm && instr_in.op == cpx_pkg::OP_ADDR_ADD
    |=> pc_out == $past(pc_out) + 20'h00004 + $past(instr_in.imm)) else $error("addr add on pc wrong");
  a_addr_sub_pc: assert property (pc_imm && instr_in.op == cpx_pkg::OP_ADDR_SUB
    |=> pc_out == $past(pc_out) + 20'h00004 - $past(instr_in.imm)) else $error("addr sub on pc wrong");
  a_ext_add_pc: assert property (pc_imm && instr_in.op == cpx_pkg::OP_EXT_ADD
    |=> pc_out == $past(pc_out) + 20'h00006 + $past(instr_in.imm)) else $error("ext add on pc wrong");
  a_mov_sets_pc: assert property (pc_imm && instr_in.op == cpx_pkg::OP_MOV_IMM
    |=> pc_out == $past(instr_in.imm)) else $error("mov to pc wrong");
  a_push_lowers_sp: assert property (take && instr_in.op == cpx_pkg::OP_PUSH_20BIT
    |=> sp_out == $past(sp_out) - 20'h00004 && stack_req_out.wr && stack_req_out.addr == sp_out)
    else $error("push sp update wrong");
  a_req_held: assert property (busy && !stack_ack_in |=> $stable(stack_req_out))
    else $error("stack request dropped early");
  a_busy_blocks: assert property (busy |-> !instr_ready_out)
    else $error("ready while stack access pending");
endmodule

bind cpx_exec cpx_exec_checker cpx_exec_checker_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
  .instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_ready_out(instr_ready_out),
  .stack_req_out(stack_req_out), .stack_ack_in(stack_ack_in), .pc_out(pc_out), .sp_out(sp_out),
  .halted_out(halted_out), .trace_valid_out(trace_valid_out), .trace_out(trace_out));

// *** cpx_exec_tb_top.sv ***
// testbench: directed scenarios for the pc/sp corner-case execute stage
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cpx_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in;
  logic reset_n_in;
  logic instr_valid_in;
  cpx_pkg::cpx_instr_t instr_in;
  logic instr_ready_out;
  cpx_pkg::cpx_stack_req_t stack_req_out;
  logic [19:0] stack_rdata_in;
  logic stack_ack_in;
  logic [19:0] pc_out;
  logic [19:0] sp_out;
  logic [15:0] status_flags_reg_out;
  logic halted_out;
  logic trace_valid_out;
  cpx_pkg::cpx_trace_t trace_out;
  logic [3:0] delay = 4'h0;
  logic [19:0] epc = 20'h00000;
  logic [19:0] esp = 20'h00000;
  logic epc_ok = 1'b1;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  cpx_exec cpx_exec_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .instr_ready_out(instr_ready_out), .stack_req_out(stack_req_out),
    .stack_rdata_in(stack_rdata_in), .stack_ack_in(stack_ack_in), .pc_out(pc_out), .sp_out(sp_out),
    .status_flags_reg_out(status_flags_reg_out), .halted_out(halted_out), .trace_valid_out(trace_valid_out),
    .trace_out(trace_out));
  cpx_stack_mem cpx_stack_mem_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .req_in(stack_req_out),
    .delay_in(delay), .rdata_out(stack_rdata_in), .ack_out(stack_ack_in));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic cpx_pkg::cpx_instr_t mk(input cpx_pkg::cpx_op_t o, input cpx_pkg::cpx_mode_t m,
      input cpx_pkg::cpx_reg_t d, input logic [19:0] im, input logic [19:0] sv);
    mk = '{o, m, d, d, cpx_pkg::JC_NONZERO, cpx_pkg::ROT_RLA, im, sv};
  endfunction
  // valid stays up after the take so back-to-back issues need no gap
  task automatic issue(input cpx_pkg::cpx_instr_t i);
    instr_valid_in = 1'b1;
    instr_in = i;
    while (instr_ready_out !== 1'b1)
    begin
      @(posedge ref_clk_in);
      #1;
    end
    @(posedge ref_clk_in);
    #1;
    `CHK(trace_valid_out, 1'b1)
    if (epc_ok)
      `CHK(trace_out.pc, epc)
  endtask
  task automatic drop();
    instr_valid_in = 1'b0;
    @(posedge ref_clk_in);
    #1;
    while (instr_ready_out !== 1'b1)
    begin
      @(posedge ref_clk_in);
      #1;
    end
  endtask
  task automatic step(input cpx_pkg::cpx_op_t o, input logic [19:0] im, input logic [19:0] exp);
    issue(mk(o, cpx_pkg::MODE_IMM, cpx_pkg::REG_PC, im, 20'h00000));
    `CHK(pc_out, exp)
    epc = exp;
    epc_ok = 1'b1;
  endtask
  task automatic t_pc_arith();
    step(cpx_pkg::OP_MOV_IMM, 20'h10000, 20'h10000);
    step(cpx_pkg::OP_ADDR_ADD, 20'h00010, 20'h10014);
    step(cpx_pkg::OP_ADDR_SUB, 20'h00008, 20'h10010);
    step(cpx_pkg::OP_ADDR_COMPARE, 20'h10014, 20'h10014);
    `CHK(status_flags_reg_out[cpx_pkg::FLAG_Z], 1'b1)
    step(cpx_pkg::OP_EXT_ADD, 20'h00100, 20'h1011a);
    step(cpx_pkg::OP_EXT_SUB, 20'h00016, 20'h1010a);
    step(cpx_pkg::OP_EXT_COMPARE, 20'h10110, 20'h10110);
    `CHK(status_flags_reg_out[cpx_pkg::FLAG_Z], 1'b1)
  endtask
  task automatic t_push_sp();
    delay = 4'h3;
    issue(mk(cpx_pkg::OP_PUSH_20BIT, cpx_pkg::MODE_INC, cpx_pkg::REG_SP, 20'h00000, 20'h0abcd));
    `CHK(stack_req_out.addr, esp - 20'h00004)
    drop();
    esp = esp - 20'h00004;
    epc = epc + 20'h00002;
    `CHK(sp_out, esp)
    `CHK(cpx_stack_mem_i.mem[esp], 20'h0abcd)
  endtask
  task automatic t_call_pc();
    delay = 4'h0;
    issue(mk(cpx_pkg::OP_CALL_20BIT, cpx_pkg::MODE_REG, cpx_pkg::REG_PC, 20'h00000, 20'h00000));
    drop();
    esp = esp - 20'h00004;
    epc = epc + 20'h00002;
    `CHK(cpx_stack_mem_i.mem[esp], epc)
    `CHK(pc_out, epc)
  endtask
  // every push mode followed at once by a negative-index stack call
  task automatic t_push_call();
    logic [19:0] tgt;
    for (int k = 0; k < 7; k++)
    begin
      delay = k[0] ? 4'h0 : 4'h2;
      tgt = 20'h30000 | (20'(k) << 6);
      cpx_stack_mem_i.mem[esp - 20'h0000c] = tgt;
      issue(mk(cpx_pkg::OP_PUSH_20BIT, cpx_pkg::cpx_mode_t'(k), cpx_pkg::REG_PC, 20'h00010, 20'h05555));
      esp = esp - 20'h00004;
      epc = epc + 20'h00002;
      issue(mk(cpx_pkg::OP_CALL_20BIT_IDX, cpx_pkg::MODE_IDX, cpx_pkg::REG_SP, 20'h0fff8, 20'h00000));
      `CHK(stack_req_out.addr, esp - 20'h00008)
      drop();
      `CHK(cpx_stack_mem_i.mem[esp - 20'h00004], epc + 20'h00004)
      `CHK(pc_out, tgt)
      esp = esp - 20'h00004;
      epc = tgt;
    end
  endtask
  task automatic t_jump_rot();
    cpx_pkg::cpx_instr_t i;
    step(cpx_pkg::OP_MOV_IMM, 20'h00400, 20'h00400);
    issue(mk(cpx_pkg::OP_BIT_TEST, cpx_pkg::MODE_IND, cpx_pkg::REG_PC, 20'h00000, 20'h00002));
    `CHK(status_flags_reg_out[cpx_pkg::FLAG_Z], 1'b0)
    epc = 20'h00402;
    issue(mk(cpx_pkg::OP_COND_JUMP, cpx_pkg::MODE_REG, cpx_pkg::REG_PC, 20'hffffe, 20'h00000));
    `CHK(pc_out, 20'h00400)
    epc = 20'h00400;
    step(cpx_pkg::OP_ADDR_COMPARE, 20'h00404, 20'h00404);
    issue(mk(cpx_pkg::OP_COND_JUMP, cpx_pkg::MODE_REG, cpx_pkg::REG_PC, 20'hffffe, 20'h00000));
    `CHK(pc_out, 20'h00406)
    epc = 20'h00406;
    issue(mk(cpx_pkg::OP_ROTATE, cpx_pkg::MODE_REG, cpx_pkg::REG_PC, 20'h00000, 20'h00000));
    `CHK(pc_out, 20'h00810)
    for (int c = 0; c < 7; c++)
    begin
      epc_ok = 1'b0;
      step(cpx_pkg::OP_MOV_IMM, 20'h00200, 20'h00200);
      i = mk(cpx_pkg::OP_COND_JUMP, cpx_pkg::MODE_REG, cpx_pkg::REG_PC, 20'h00000, 20'h00000);
      i.cond = cpx_pkg::cpx_cond_t'(c);
      issue(i);
      `CHK(pc_out, 20'h00202)
      epc = 20'h00202;
      i = mk(cpx_pkg::OP_ROTATE, cpx_pkg::MODE_REG, cpx_pkg::REG_PC, 20'h00000, 20'h00000);
      i.rot = cpx_pkg::cpx_rot_t'(c[1:0]);
      issue(i);
      `CHK(halted_out, 1'b0)
    end
    epc_ok = 1'b0;
    step(cpx_pkg::OP_MOV_IMM, 20'h00300, 20'h00300);
    drop();
  endtask
  task automatic stop_test();
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  // far above the roughly 130 cycles the scenarios need
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    reset_n_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_in = '0;
    repeat (4) @(posedge ref_clk_in);
    #1;
    reset_n_in = 1'b1;
    t_pc_arith();
    t_push_sp();
    t_call_pc();
    t_push_call();
    t_jump_rot();
    stop_test();
  end
endmodule

// *** cpx_pkg.sv ***
// package: opcodes, modes and carriers for the pc/sp corner-case execute stage
package cpx_pkg;

  localparam int unsigned ADDR_W = 20;
  localparam int unsigned WORD_W = 16;

  // encoding lengths in bytes, push size in bytes and pc/sp reset values
  localparam logic [19:0] LEN_ADDR_IMM = 20'h00004;
  localparam logic [19:0] LEN_BIT_IND = 20'h00002;
  localparam logic [19:0] LEN_MOV_IMM = 20'h00004;
  localparam logic [19:0] LEN_EXT_IMM = 20'h00006;
  localparam logic [19:0] LEN_CALL_REG = 20'h00002;
  localparam logic [19:0] LEN_CALL_IDX = 20'h00004;
  localparam logic [19:0] LEN_PUSH = 20'h00002;
  localparam logic [19:0] LEN_JUMP = 20'h00002;
  localparam logic [19:0] LEN_ROT = 20'h00002;
  localparam logic [19:0] PUSH_20BIT_BYTES = 20'h00004;
  localparam logic [19:0] SP_RESET = 20'h00000;
  localparam logic [19:0] PC_RESET = 20'h00000;

  // status flag positions and reset value
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 8;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ADDR_ADD = 4'h1,
    OP_ADDR_SUB = 4'h2,
    OP_ADDR_COMPARE = 4'h3,
    OP_EXT_ADD = 4'h4,
    OP_EXT_SUB = 4'h5,
    OP_EXT_COMPARE = 4'h6,
    OP_MOV_IMM = 4'h7,
    OP_PUSH_20BIT = 4'h8,
    OP_CALL_20BIT = 4'h9,
    OP_CALL_20BIT_IDX = 4'ha,
    OP_COND_JUMP = 4'hb,
    OP_ROTATE = 4'hc,
    OP_BIT_TEST = 4'hd
  } cpx_op_t;

  typedef enum logic [2:0] {
    MODE_REG = 3'h0,
    MODE_IMM = 3'h1,
    MODE_ABS = 3'h2,
    MODE_SYM = 3'h3,
    MODE_IDX = 3'h4,
    MODE_IND = 3'h5,
    MODE_INC = 3'h6
  } cpx_mode_t;

  typedef enum logic [2:0] {
    JC_ZERO = 3'h0,
    JC_NONZERO = 3'h1,
    JC_CARRY = 3'h2,
    JC_NO_CARRY = 3'h3,
    JC_NEGATIVE = 3'h4,
    JC_GREATER_EQUAL = 3'h5,
    JC_LESS = 3'h6
  } cpx_cond_t;

  typedef enum logic [1:0] {
    ROT_RRC = 2'h0,
    ROT_RRA = 2'h1,
    ROT_RLA = 2'h2,
    ROT_RRU = 2'h3
  } cpx_rot_t;

  typedef enum logic [3:0] {
    REG_PC = 4'h0,
    REG_SP = 4'h1,
    REG_SR = 4'h2
  } cpx_reg_t;

  // decoded instruction presented by fetch
  typedef struct packed {
    cpx_op_t op;
    cpx_mode_t mode;
    cpx_reg_t dst;
    cpx_reg_t src;
    cpx_cond_t cond;
    cpx_rot_t rot;
    logic [19:0] imm;
    logic [19:0] src_val;
  } cpx_instr_t;

  // stack memory request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [19:0] addr;
    logic [19:0] wdata;
  } cpx_stack_req_t;

  // trace record
  typedef struct packed {
    logic [19:0] pc;
    cpx_op_t op;
  } cpx_trace_t;

endpackage

// *** cpx_stack_mem.sv ***
// stack memory model answering the execute stage after a set number of cycles
module cpx_stack_mem
  (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // request side
    input wire cpx_pkg::cpx_stack_req_t req_in,
    input wire logic [3:0] delay_in,
    // answer side
    output logic [19:0] rdata_out,
    output logic ack_out
  );
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] mem [logic [19:0]];
  logic [3:0] cnt_q;
  // read data toggles every cycle except the ack of a read from a stored address, so stale data never holds steady
  always @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_q <= 4'h0;
      ack_out <= 1'b0;
      rdata_out <= 20'h00000;
    end
    else
    begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if ((req_in.rd || req_in.wr) && !ack_out)
      begin
        if (cnt_q >= delay_in)
        begin
          ack_out <= 1'b1;
          cnt_q <= 4'h0;
          if (req_in.wr)
            mem[req_in.addr] = req_in.wdata;
          else if (mem.exists(req_in.addr))
            rdata_out <= mem[req_in.addr];
        end
        else
          cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
